// ### wdsm_top.v
// Watchdog timer with supply and charge-pump monitoring, register file included.
// Assumes a simple register port on mclk, raw asynchronous detector and oscillator pins,
// and sleep/standby levels from the mode sequencer on mclk.
`timescale 1ns/1ps
`include "wdsm_defines.vh"

module wdsm_top
#(
  parameter PROC_RST_CYCLES = 16'd1000,
  parameter SYS_RST_CYCLES  = 16'd8000
)
(
  // Clock and reset
  input  wire       mclk,
  input  wire       arst_n,
  // Register port
  input  wire [7:0] reg_addr,
  input  wire       reg_wr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  // Pins from the analog die
  input  wire       slow_oscillator,
  input  wire       overvoltage_det,
  input  wire       undervoltage_det,
  input  wire       pump_fault_det,
  // Mode levels from the sequencer
  input  wire       sleep_mode,
  input  wire       standby_mode,
  // Results
  output reg        processor_reset,
  output reg        system_reset,
  output reg        wakeup_event,
  output reg        supply_error_flag,
  output reg        drivers_off
);

  localparam [31:0] DEB_CYCLES = (`WDSM_DEBOUNCE_NS * (`WDSM_CLK_KHZ / 1000) + 999) / 1000;
  localparam [11:0] DEB_LAST  = DEB_CYCLES[11:0] - 12'h001;
  localparam [10:0] BASE_LAST = `WDSM_BASE_TICKS - 11'h001;

  // ==========================================================
  // Synchronisers: three stages, change accepted when stages two and three agree
  reg [2:0] osc_sync_reg;
  reg [2:0] ov_sync_reg;
  reg [2:0] uv_sync_reg;
  reg [2:0] cp_sync_reg;
  reg       osc_lvl_reg;
  reg [2:0] raw_lvl_reg;

  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      osc_sync_reg <= 3'h0;
      ov_sync_reg  <= 3'h0;
      uv_sync_reg  <= 3'h0;
      cp_sync_reg  <= 3'h0;
      osc_lvl_reg  <= 1'b0;
      raw_lvl_reg  <= 3'h0;
    end
    else
    begin
      osc_sync_reg <= {osc_sync_reg[1:0], slow_oscillator};
      ov_sync_reg  <= {ov_sync_reg[1:0], overvoltage_det};
      uv_sync_reg  <= {uv_sync_reg[1:0], undervoltage_det};
      cp_sync_reg  <= {cp_sync_reg[1:0], pump_fault_det};
      if (osc_sync_reg[1] == osc_sync_reg[2])
        osc_lvl_reg <= osc_sync_reg[2];
      if (ov_sync_reg[1] == ov_sync_reg[2])
        raw_lvl_reg[0] <= ov_sync_reg[2];
      if (uv_sync_reg[1] == uv_sync_reg[2])
        raw_lvl_reg[1] <= uv_sync_reg[2];
      if (cp_sync_reg[1] == cp_sync_reg[2])
        raw_lvl_reg[2] <= cp_sync_reg[2];
    end
  end

  // One tick per rising edge of the slow oscillator.
  wire slow_tick = osc_sync_reg[1] & osc_sync_reg[2] & ~osc_lvl_reg;

  // ==========================================================
  // Debounce: a level must hold for 20 us before the filtered state follows it
  reg [11:0] deb_cnt_reg [0:2];
  reg [2:0]  deb_lvl_reg;
  integer    i;

  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (i = 0; i < 3; i = i + 1)
        deb_cnt_reg[i] <= 12'h000;
      deb_lvl_reg <= 3'h0;
    end
    else
    begin
      for (i = 0; i < 3; i = i + 1)
      begin
        if (raw_lvl_reg[i] == deb_lvl_reg[i])
          deb_cnt_reg[i] <= 12'h000;
        else if (deb_cnt_reg[i] == DEB_LAST)
        begin
          deb_lvl_reg[i] <= raw_lvl_reg[i];
          deb_cnt_reg[i] <= 12'h000;
        end
        else
          deb_cnt_reg[i] <= deb_cnt_reg[i] + 12'h001;
      end
    end
  end

  wire ov_now = deb_lvl_reg[0];
  wire uv_now = deb_lvl_reg[1];
  wire cp_now = deb_lvl_reg[2];

  // ==========================================================
  // Register writes
  reg  [7:0] wdconf_reg;
  reg  [7:0] mode_reg;
  reg  [7:0] status_reg;
  reg  [7:0] status_next;
  reg        sleep_d_reg;

  wire wr_status = reg_wr && (reg_addr == `WDSM_ADDR_STATUS);
  wire wr_mode   = reg_wr && (reg_addr == `WDSM_ADDR_MODE);
  wire wr_conf   = reg_wr && (reg_addr == `WDSM_ADDR_WDCONF);
  wire locked    = wdconf_reg[`WDSM_CFG_LOCK];
  wire wd_en     = wdconf_reg[`WDSM_CFG_EN];
  // The host inverts the clear bit; any write that changes it services the watchdog.
  wire wd_clear  = wr_conf && (reg_wdata[`WDSM_CFG_CLR] != wdconf_reg[`WDSM_CFG_CLR]);

  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wdconf_reg <= `WDSM_WDCONF_RESET;
      mode_reg   <= `WDSM_MODE_RESET;
    end
    else
    begin
      if (wr_conf)
      begin
        wdconf_reg[`WDSM_CFG_CLR] <= reg_wdata[`WDSM_CFG_CLR];
        if (!locked)
        begin
          wdconf_reg[`WDSM_CFG_EN]   <= reg_wdata[`WDSM_CFG_EN];
          wdconf_reg[`WDSM_CFG_LOCK] <= reg_wdata[`WDSM_CFG_LOCK];
          if (!wd_en)
            wdconf_reg[`WDSM_CFG_STO_HI:`WDSM_CFG_PTO_LO] <=
              reg_wdata[`WDSM_CFG_STO_HI:`WDSM_CFG_PTO_LO];
        end
      end
      if (wr_mode)
        mode_reg <= {1'b0, reg_wdata[6:2], 2'b00};
    end
  end

  // ==========================================================
  // Watchdog counters
  reg [10:0] base_reg;
  reg [7:0]  post_proc_reg;
  reg [3:0]  post_sys_reg;
  reg [15:0] pulse_cnt_reg;
  reg        proc_evt;
  reg        sys_evt;
  reg        wake_evt;

  function [7:0] proc_last;
    input [2:0] code;
    begin
      proc_last = (8'h01 << code) - 8'h01;
    end
  endfunction

  function [3:0] sys_count;
    input [1:0] code;
    begin
      case (code)
        2'b01:   sys_count = 4'h1;
        2'b10:   sys_count = 4'h4;
        2'b11:   sys_count = 4'h8;
        default: sys_count = 4'h0;
      endcase
    end
  endfunction

  wire [2:0] pto      = wdconf_reg[`WDSM_CFG_PTO_HI:`WDSM_CFG_PTO_LO];
  wire [1:0] sto      = wdconf_reg[`WDSM_CFG_STO_HI:`WDSM_CFG_STO_LO];
  wire       lowpower = sleep_mode | standby_mode;
  wire       wd_run   = wd_en && (!lowpower || mode_reg[`WDSM_MODE_LPRUN]);
  wire       base_end = slow_tick && (base_reg == BASE_LAST);
  wire       pto_hit  = base_end && (post_proc_reg == proc_last(pto));
  wire [3:0] sys_cnt1 = post_sys_reg + 4'h1;
  wire       sto_hit  = (sto != 2'b00) && (sys_cnt1 == sys_count(sto));

  always @*
  begin
    proc_evt = 1'b0;
    sys_evt  = 1'b0;
    wake_evt = 1'b0;
    if (wd_run && pto_hit)
    begin
      if (standby_mode)
        wake_evt = 1'b1;
      else if (sto_hit && sleep_mode)
        wake_evt = 1'b1;
      else if (sto_hit)
        sys_evt = 1'b1;
      else if (!sleep_mode)
        proc_evt = 1'b1;
    end
  end

  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      base_reg      <= 11'h000;
      post_proc_reg <= 8'h00;
      post_sys_reg  <= 4'h0;
    end
    else if (!wd_en || wd_clear)
    begin
      base_reg      <= 11'h000;
      post_proc_reg <= 8'h00;
      post_sys_reg  <= 4'h0;
    end
    else if (wd_run && slow_tick)
    begin
      base_reg <= base_end ? 11'h000 : base_reg + 11'h001;
      if (pto_hit)
      begin
        post_proc_reg <= 8'h00;
        post_sys_reg  <= (sto_hit || standby_mode) ? 4'h0 : sys_cnt1;
      end
      else if (base_end)
        post_proc_reg <= post_proc_reg + 8'h01;
    end
  end

  // ==========================================================
  // Reset pulse generation
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pulse_cnt_reg   <= 16'h0000;
      processor_reset <= 1'b0;
      system_reset    <= 1'b0;
      wakeup_event    <= 1'b0;
    end
    else
    begin
      wakeup_event <= wake_evt;
      if (sys_evt)
      begin
        pulse_cnt_reg <= SYS_RST_CYCLES;
        system_reset  <= 1'b1;
        processor_reset <= 1'b1;
      end
      else if (proc_evt)
      begin
        pulse_cnt_reg   <= PROC_RST_CYCLES;
        processor_reset <= 1'b1;
      end
      else if (pulse_cnt_reg > 16'h0001)
        pulse_cnt_reg <= pulse_cnt_reg - 16'h0001;
      else
      begin
        pulse_cnt_reg   <= 16'h0000;
        processor_reset <= 1'b0;
        system_reset    <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Status flags: set always beats a host or automatic clear
  wire       sleep_exit = sleep_d_reg & ~sleep_mode;
  wire [7:0] w1c        = wr_status ? reg_wdata : 8'h00;

  always @*
  begin
    status_next = status_reg;
    if (w1c[`WDSM_ST_POR])
      status_next[`WDSM_ST_POR] = 1'b0;
    if (w1c[`WDSM_ST_PROC])
      status_next[`WDSM_ST_PROC] = 1'b0;
    if (w1c[`WDSM_ST_SYS])
      status_next[`WDSM_ST_SYS] = 1'b0;
    if ((w1c[`WDSM_ST_OV] || mode_reg[`WDSM_MODE_SAC]) && !ov_now)
      status_next[`WDSM_ST_OV] = 1'b0;
    if ((w1c[`WDSM_ST_UV] || mode_reg[`WDSM_MODE_SAC]) && !uv_now)
      status_next[`WDSM_ST_UV] = 1'b0;
    if ((w1c[`WDSM_ST_PUMP] || mode_reg[`WDSM_MODE_PAC]) && !cp_now)
      status_next[`WDSM_ST_PUMP] = 1'b0;
    if (proc_evt)
      status_next[`WDSM_ST_PROC] = 1'b1;
    if (sys_evt)
      status_next[`WDSM_ST_SYS] = 1'b1;
    if (ov_now)
      status_next[`WDSM_ST_OV] = 1'b1;
    if (uv_now)
      status_next[`WDSM_ST_UV] = 1'b1;
    if (cp_now || sleep_exit)
      status_next[`WDSM_ST_PUMP] = 1'b1;
  end

  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      status_reg        <= `WDSM_STATUS_RESET;
      sleep_d_reg       <= 1'b0;
      supply_error_flag <= 1'b0;
      drivers_off       <= 1'b1;
    end
    else
    begin
      status_reg        <= status_next;
      sleep_d_reg       <= sleep_mode;
      supply_error_flag <= status_next[`WDSM_ST_OV] | status_next[`WDSM_ST_UV];
      drivers_off       <= (status_next[`WDSM_ST_OV] & mode_reg[`WDSM_MODE_OVP]) |
                           (status_next[`WDSM_ST_UV] & mode_reg[`WDSM_MODE_UVP]) |
                           status_next[`WDSM_ST_PUMP];
    end
  end

  // ==========================================================
  // Read data, registered; unmapped offsets read zero
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata <= 8'h00;
    else
    begin
      case (reg_addr)
        `WDSM_ADDR_STATUS: reg_rdata <= status_reg;
        `WDSM_ADDR_MODE:   reg_rdata <= mode_reg;
        `WDSM_ADDR_WDCONF: reg_rdata <= wdconf_reg;
        default:           reg_rdata <= 8'h00;
      endcase
    end
  end

endmodule

// ### wdsm_defines.vh
// Constants for the watchdog and supply monitor block.
// Assumes inclusion by bare name from the design file in the same folder.
`ifndef WDSM_DEFINES_VH
`define WDSM_DEFINES_VH

// ==========================================================
// Register offsets
`define WDSM_ADDR_STATUS     8'h00
`define WDSM_ADDR_MODE       8'h03
`define WDSM_ADDR_WDCONF     8'h04

// ==========================================================
// Reset values
`define WDSM_STATUS_RESET    8'h41
`define WDSM_MODE_RESET      8'h0c
`define WDSM_WDCONF_RESET    8'h11

// ==========================================================
// Field positions of watchdog_config
`define WDSM_CFG_EN          0
`define WDSM_CFG_LOCK        1
`define WDSM_CFG_PTO_LO      2
`define WDSM_CFG_PTO_HI      4
`define WDSM_CFG_STO_LO      5
`define WDSM_CFG_STO_HI      6
`define WDSM_CFG_CLR         7

// ==========================================================
// Field positions of mode_control
`define WDSM_MODE_UVP        2
`define WDSM_MODE_OVP        3
`define WDSM_MODE_LPRUN      4
`define WDSM_MODE_SAC        5
`define WDSM_MODE_PAC        6

// ==========================================================
// Field positions of reset_error_status
`define WDSM_ST_POR          0
`define WDSM_ST_PROC         1
`define WDSM_ST_SYS          2
`define WDSM_ST_UV           4
`define WDSM_ST_OV           5
`define WDSM_ST_PUMP         6

// ==========================================================
// Timing
`define WDSM_CLK_KHZ         125000
`define WDSM_DEBOUNCE_NS     20000
`define WDSM_BASE_TICKS      11'h4e2

`endif

// ### wdsm_osc_model.sv
// Model of the free-running slow oscillator that times the watchdog.
// Assumes a short period so that a full time-out fits in the run.
`timescale 1ns/1ps

module wdsm_osc_model
#(
  parameter real HALF_NS = 23.5
)
(
  // Oscillator pin
  output reg slow_oscillator
);
  // It never stops, so the watchdog keeps counting in low-power modes whenever the low-power run bit is set.
  initial
  begin
    slow_oscillator = 1'b0;
    forever #(HALF_NS) slow_oscillator = ~slow_oscillator;
  end
endmodule

// ### wdsm_checker_sva.sv
// Port checker for the watchdog and supply monitor.
// Assumes it is bound to wdsm_top and sees only that module's ports.
`timescale 1ns/1ps

module wdsm_checker
#(
  parameter PROC_RST_CYCLES = 16'd1000,
  parameter SYS_RST_CYCLES  = 16'd8000
)
(
  // Clock, reset and register port
  input wire       mclk,
  input wire       arst_n,
  input wire [7:0] reg_addr,
  input wire       reg_wr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  // Pins and mode levels
  input wire       slow_oscillator,
  input wire       overvoltage_det,
  input wire       undervoltage_det,
  input wire       pump_fault_det,
  input wire       sleep_mode,
  input wire       standby_mode,
  // Results
  input wire       processor_reset,
  input wire       system_reset,
  input wire       wakeup_event,
  input wire       supply_error_flag,
  input wire       drivers_off
);
  // ==========================================================
  // Pulse length counters
  reg [15:0] proc_cnt_reg;
  reg [15:0] sys_cnt_reg;
  always @(posedge mclk or negedge arst_n)
    if (!arst_n)
    begin
      proc_cnt_reg <= 16'h0000;
      sys_cnt_reg  <= 16'h0000;
    end
    else
    begin
      proc_cnt_reg <= processor_reset ? proc_cnt_reg + 16'h0001 : 16'h0000;
      sys_cnt_reg  <= system_reset ? sys_cnt_reg + 16'h0001 : 16'h0000;
    end

  // ==========================================================
  // Properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  sequence s_wake_done;
    wakeup_event ##1 !wakeup_event;
  endsequence

  // A pulse that overlapped a system reset is longer and judged by a_sys_len.
  property p_proc_len;
    $fell(processor_reset) && proc_cnt_reg < SYS_RST_CYCLES |-> proc_cnt_reg == PROC_RST_CYCLES;
  endproperty
  a_proc_len: assert property (p_proc_len) else $error("processor reset length wrong");
  property p_sys_len;
    $fell(system_reset) |-> sys_cnt_reg == SYS_RST_CYCLES;
  endproperty
  a_sys_len: assert property (p_sys_len) else $error("system reset length wrong");
  property p_sys_proc;
    system_reset |-> processor_reset;
  endproperty
  a_sys_proc: assert property (p_sys_proc) else $error("system reset without processor reset");
  property p_wake;
    $rose(wakeup_event) |-> s_wake_done;
  endproperty
  a_wake: assert property (p_wake) else $error("wake-up pulse not one cycle");
  property p_wake_mode;
    $rose(wakeup_event) |-> $past(sleep_mode) || $past(standby_mode);
  endproperty
  a_wake_mode: assert property (p_wake_mode) else $error("wake-up outside low power");
  property p_start_off;
    $rose(arst_n) |-> drivers_off;
  endproperty
  a_start_off: assert property (p_start_off) else $error("drivers on after reset");
  property p_mode_rd;
    reg_addr == 8'h03 |=> reg_rdata[7] == 1'b0 && reg_rdata[1:0] == 2'h0;
  endproperty
  a_mode_rd: assert property (p_mode_rd) else $error("mode spare bits read set");
  property p_debounce;
    $rose(supply_error_flag) |-> $past(overvoltage_det, 8) || $past(undervoltage_det, 8);
  endproperty
  a_debounce: assert property (p_debounce) else $error("supply flag without long event");
endmodule

bind wdsm_top wdsm_checker
#(
  .PROC_RST_CYCLES(PROC_RST_CYCLES),
  .SYS_RST_CYCLES (SYS_RST_CYCLES)
) chk_u (
  .mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .slow_oscillator(slow_oscillator),
  .overvoltage_det(overvoltage_det), .undervoltage_det(undervoltage_det),
  .pump_fault_det(pump_fault_det), .sleep_mode(sleep_mode), .standby_mode(standby_mode),
  .processor_reset(processor_reset), .system_reset(system_reset),
  .wakeup_event(wakeup_event), .supply_error_flag(supply_error_flag),
  .drivers_off(drivers_off)
);

// ### watchdog_supply_monitor_tb.sv
// Self-checking bench for the watchdog and supply monitor.
// Assumes wdsm_top, its checker and the oscillator model are compiled first.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  $display("FAIL %s exp %h got %h", nm, e, g); fail_count++; end end

module watchdog_supply_monitor_tb;
  reg        mclk;
  reg        arst_n;
  reg  [7:0] reg_addr;
  reg        reg_wr;
  reg  [7:0] reg_wdata;
  wire [7:0] reg_rdata;
  wire       slow_oscillator;
  reg        overvoltage_det;
  reg        undervoltage_det;
  reg        pump_fault_det;
  reg        sleep_mode;
  reg        standby_mode;
  wire       processor_reset;
  wire       system_reset;
  wire       wakeup_event;
  wire       supply_error_flag;
  wire       drivers_off;
  integer    fail_count;
  integer    samples_checked;
  integer    cycles;
  integer    seed;
  integer    n;
  reg        rd_req;
  reg        rd_d;
  reg  [7:0] ex;
  reg  [7:0] exp_q[$];

  wdsm_top #(.PROC_RST_CYCLES(16'd4), .SYS_RST_CYCLES(16'd16)) dut_u (
    .mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .slow_oscillator(slow_oscillator),
    .overvoltage_det(overvoltage_det), .undervoltage_det(undervoltage_det),
    .pump_fault_det(pump_fault_det), .sleep_mode(sleep_mode), .standby_mode(standby_mode),
    .processor_reset(processor_reset), .system_reset(system_reset),
    .wakeup_event(wakeup_event), .supply_error_flag(supply_error_flag),
    .drivers_off(drivers_off));
  wdsm_osc_model osc_u (.slow_oscillator(slow_oscillator));

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // ==========================================================
  // Read results are compared here, one cycle after the address.
  always @(posedge mclk)
  begin
    rd_d <= rd_req;
    cycles = cycles + 1;
    if (rd_d)
    begin
      ex = exp_q.pop_front();
      `CHK("reg_rdata", ex, reg_rdata)
    end
    if (cycles == 80000)
    begin
      fail_count = fail_count + 1;
      summarize;
    end
  end

  task summarize;
  begin
    if (fail_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask

  task wr(input [7:0] a, input [7:0] d);
  begin
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  end
  endtask

  task rd(input [7:0] a, input [7:0] e);
  begin
    @(posedge mclk);
    reg_addr <= a;
    rd_req   <= 1'b1;
    exp_q.push_back(e);
    @(posedge mclk);
    rd_req <= 1'b0;
    @(posedge mclk);
    #1;
  end
  endtask

  // Bounded wait: 0 processor reset, 1 wake-up, 2 system reset.
  task wait_hi(input integer sel);
  begin
    n = 0;
    while (n < 9000 && !(sel == 0 ? processor_reset === 1'b1 :
           sel == 1 ? wakeup_event === 1'b1 : system_reset === 1'b1))
    begin
      @(posedge mclk);
      #1;
      n = n + 1;
    end
  end
  endtask

  task hold(input integer which, input integer len);
  begin
    @(posedge mclk);
    if (which == 0) overvoltage_det <= 1'b1; else undervoltage_det <= 1'b1;
    repeat (len) @(posedge mclk);
    if (which == 0) overvoltage_det <= 1'b0; else undervoltage_det <= 1'b0;
  end
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    seed = 32'h46b82198;
    fail_count = 0;
    samples_checked = 0;
    cycles = 0;
    {arst_n, reg_addr, reg_wr, reg_wdata, rd_req} = 0;
    {overvoltage_det, undervoltage_det, pump_fault_det, sleep_mode, standby_mode} = 0;
    repeat (8) @(posedge mclk);
    arst_n <= 1'b1;
    rd(8'h00, 8'h41);
    rd(8'h03, 8'h0c);
    rd(8'h04, 8'h11);
    rd(8'h05, 8'h00);
    wr(8'h04, 8'h00);
    rd(8'h04, 8'h10);
    wr(8'h00, 8'h41);
    rd(8'h00, 8'h00);
    `CHK("drivers_off", 1'b0, drivers_off)
    hold(0, 200 + ($random(seed) & 1023));
    repeat (2700) @(posedge mclk);
    rd(8'h00, 8'h00);
    @(posedge mclk);
    overvoltage_det <= 1'b1;
    repeat (2700) @(posedge mclk);
    #1;
    `CHK("supply_error_flag", 1'b1, supply_error_flag)
    `CHK("drivers_off", 1'b1, drivers_off)
    wr(8'h00, 8'h20);
    rd(8'h00, 8'h20);
    @(posedge mclk);
    overvoltage_det <= 1'b0;
    repeat (2700) @(posedge mclk);
    wr(8'h00, 8'h20);
    rd(8'h00, 8'h00);
    `CHK("drivers_off", 1'b0, drivers_off)
    wr(8'h03, 8'h2c);
    hold(1, 2700);
    rd(8'h00, 8'h10);
    `CHK("drivers_off", 1'b1, drivers_off)
    repeat (2700) @(posedge mclk);
    rd(8'h00, 8'h00);
    `CHK("supply_error_flag", 1'b0, supply_error_flag)
    wr(8'h04, 8'h01);
    wr(8'h04, 8'h1d);
    rd(8'h04, 8'h01);
    // Service half way; the time-out must then count a full period from the clear.
    repeat (4000) @(posedge mclk);
    wr(8'h04, 8'h81);
    wait_hi(0);
    `CHK("proc_timeout", 1'b1, n > 6700 && n < 9000)
    repeat (8) @(posedge mclk);
    rd(8'h00, 8'h02);
    wr(8'h04, 8'h00);
    // Standby without the low-power run bit freezes the count until the bit is set.
    @(posedge mclk);
    standby_mode <= 1'b1;
    wr(8'h04, 8'h01);
    repeat (4000) @(posedge mclk);
    wr(8'h03, 8'h1c);
    wait_hi(1);
    `CHK("wake_timeout", 1'b1, n > 6700 && n < 9000)
    `CHK("processor_reset", 1'b0, processor_reset)
    @(posedge mclk);
    standby_mode <= 1'b0;
    // A disable half way must zero the base counter and post-scalers, so a full period follows.
    repeat (4000) @(posedge mclk);
    wr(8'h04, 8'h00);
    wr(8'h04, 8'h21);
    wait_hi(2);
    `CHK("sys_timeout", 1'b1, n > 6700 && n < 9000)
    repeat (2) @(posedge mclk);
    #1;
    `CHK("processor_reset", 1'b1, processor_reset)
    @(posedge mclk);
    sleep_mode <= 1'b1;
    wait_hi(1);
    `CHK("sleep_wake", 1'b1, n < 9000)
    `CHK("system_reset", 1'b0, system_reset)
    @(posedge mclk);
    sleep_mode <= 1'b0;
    rd(8'h00, 8'h46);
    `CHK("drivers_off", 1'b1, drivers_off)
    repeat (20) @(posedge mclk);
    arst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    wr(8'h04, 8'h03);
    wr(8'h04, 8'h00);
    rd(8'h04, 8'h13);
    wr(8'h04, 8'h80);
    rd(8'h04, 8'h93);
    summarize;
  end
endmodule
